// ---- rtl/bpsw_fsm.v ----
// Notes on behaviour
// - Deep cell with charger: gate 7/8, recheck charger
// - Cycling returns to on when cells in range
// - Pack low, charger found: 1/8 mode
// - Charger flag is sole charger presence indication
// - Pack low clears: move to 7/8 mode
// - Load short opens switch until load removed
// - Sink on after short until removed/deep/pack low
// - Open centre tap opens switch until restored
// - Open tap, pack low, charger: 1/8 charge
// - Each cell in exactly one voltage class
// - Pack low independent of cell classes
// - Load current zero, normal or short
// - Duty fraction is gate on portion
// - Pack lockout implies switch already open
// - Overcharge cut after two ticks persist plus programmed delay
// - Deep cell, no charger: open, shutdown
// - Overcharged, load, no charger: switch on
`timescale 1ns/1ps
`include "bpsw_consts.vh"

module bpsw_fsm #(
  parameter TICK_CYCLES = `BPSW_TICK_CYCLES
) (
  input wire i_clk_sys,
  input wire i_resetn,
  input wire i_hi_cell_deep_discharged_cell,
  input wire i_hi_cell_overcharged,
  input wire i_lo_cell_deep_discharged_cell,
  input wire i_lo_cell_overcharged,
  input wire i_pack_low_voltage,
  input wire i_charger_present,
  input wire i_load_short,
  input wire i_load_zero,
  input wire i_tap_open,
  output reg o_switch_gate_drive,
  output reg o_short_release_sink,
  output wire o_irq,
  input wire i_awvalid,
  output wire o_awready,
  input wire [`BPSW_ADDR_W-1:0] i_awaddr,
  input wire i_wvalid,
  output wire o_wready,
  input wire [31:0] i_wdata,
  input wire [3:0] i_wstrb,
  output reg o_bvalid,
  input wire i_bready,
  output reg [1:0] o_bresp,
  input wire i_arvalid,
  output wire o_arready,
  input wire [`BPSW_ADDR_W-1:0] i_araddr,
  output reg o_rvalid,
  input wire i_rready,
  output reg [31:0] o_rdata,
  output reg [1:0] o_rresp
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [3:0] ST_IDLE = 4'h0;     // Off, no reason to conduct
  localparam [3:0] ST_NORMAL = 4'h1;   // Continuously on
  localparam [3:0] ST_DEEP_CHG = 4'h2; // 7/8 cycling
  localparam [3:0] ST_UV_CHG = 4'h3;   // 1/8 cycling
  localparam [3:0] ST_SHUTDOWN = 4'h4; // Off, low power
  localparam [3:0] ST_SHORT = 4'h5;    // Off, sink on
  localparam [3:0] ST_TAP_OFF = 4'h6;  // Off, tap open
  localparam [3:0] ST_TAP_UV = 4'h7;   // 1/8 cycling with tap open
  localparam [3:0] ST_OC_CHG = 4'h8;   // On, overcharge timing
  localparam [3:0] ST_OC_OFF = 4'h9;   // Off, overcharge cutoff
  localparam NFLAGS = 9;
  // Persistence count held at the width of the overcharge tick counter
  localparam [`BPSW_DELAY_W:0] OC_PERSIST = `BPSW_OC_PERSIST_TICKS;

  // ----------------------------------------------------------------
  // Flag synchronisers
  // ----------------------------------------------------------------
  wire [NFLAGS-1:0] raw_flags;
  reg [NFLAGS-1:0] meta_q;
  reg [NFLAGS-1:0] flags_q;
  assign raw_flags = {i_tap_open, i_load_zero, i_load_short, i_charger_present,
                      i_pack_low_voltage, i_lo_cell_overcharged,
                      i_lo_cell_deep_discharged_cell, i_hi_cell_overcharged,
                      i_hi_cell_deep_discharged_cell};

  // Two flops per flag so a slow comparator edge cannot glitch the gate
  genvar g;
  generate
    for (g = 0; g < NFLAGS; g = g + 1) begin : g_sync
      always @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
          meta_q[g] <= 1'b0;
          flags_q[g] <= 1'b0;
        end else begin
          meta_q[g] <= raw_flags[g];
          flags_q[g] <= meta_q[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Classification
  // ----------------------------------------------------------------
  // Deep discharge wins if both comparators fire, keeping one class per cell
  wire hi_deep = flags_q[0];
  wire hi_over = flags_q[1] & ~flags_q[0];
  wire lo_deep = flags_q[2];
  wire lo_over = flags_q[3] & ~flags_q[2];
  wire pack_low = flags_q[4];
  wire charger = flags_q[5];
  wire load_short = flags_q[6];
  wire load_zero = flags_q[7] & ~flags_q[6];
  wire tap_open = flags_q[8];
  wire any_deep = hi_deep | lo_deep;
  wire any_over = hi_over | lo_over;

  // ----------------------------------------------------------------
  // Oscillator tick and duty phase
  // ----------------------------------------------------------------
  reg [23:0] tick_cnt_q;
  reg [2:0] phase_q;
  wire tick = (tick_cnt_q == TICK_CYCLES[23:0] - 24'h000001);

  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      tick_cnt_q <= 24'h000000;
      phase_q <= 3'h0;
    end else begin
      tick_cnt_q <= tick ? 24'h000000 : tick_cnt_q + 24'h000001;
      if (tick) begin
        phase_q <= phase_q + 3'h1;
      end
    end
  end

  // Gate patterns: on for seven of eight ticks, or one of eight
  wire gate_7of8 = (phase_q != `BPSW_LAST_PHASE);
  wire gate_1of8 = (phase_q == 3'h0);
  // Charger is trusted only at the end of an off tick, when the switch is open
  wire off_sample = tick & (phase_q == `BPSW_LAST_PHASE);

  // ----------------------------------------------------------------
  // Registers seen by software
  // ----------------------------------------------------------------
  reg force_off_q;
  reg [`BPSW_DELAY_W-1:0] oc_delay_q;
  reg [`BPSW_IRQ_W-1:0] irq_stat_q;
  reg [`BPSW_IRQ_W-1:0] irq_mask_q;

  // Steady-state choice from the present conditions, no short and tap closed
  function [3:0] pick_state;
    input pl, chg, deep, over, lz;
    begin
      if (pl) begin
        pick_state = chg ? ST_UV_CHG : ST_SHUTDOWN;
      end else if (deep) begin
        pick_state = chg ? ST_DEEP_CHG : ST_SHUTDOWN;
      end else if (over) begin
        if (chg) begin
          pick_state = ST_OC_CHG;
        end else begin
          pick_state = lz ? ST_IDLE : ST_NORMAL;
        end
      end else begin
        pick_state = ST_NORMAL;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Protection state machine
  // ----------------------------------------------------------------
  reg [3:0] state_q;
  reg [3:0] state_d;
  reg [`BPSW_DELAY_W:0] oc_cnt_q;
  reg [`BPSW_DELAY_W:0] oc_cnt_d;
  reg [`BPSW_IRQ_W-1:0] events;
  wire [3:0] steady = pick_state(pack_low, charger, any_deep, any_over, load_zero);
  wire [`BPSW_DELAY_W:0] oc_limit = {1'b0, oc_delay_q} + OC_PERSIST;

  always @* begin
    state_d = state_q;
    oc_cnt_d = oc_cnt_q;
    events = {`BPSW_IRQ_W{1'b0}};
    if (tap_open && state_q != ST_TAP_OFF && state_q != ST_TAP_UV) begin
      // Open tap overrides everything else
      state_d = (pack_low && charger) ? ST_TAP_UV : ST_TAP_OFF;
      events[`BPSW_EV_TAP] = 1'b1;
    end else if (load_short && o_switch_gate_drive && state_q != ST_SHORT) begin
      state_d = ST_SHORT;
      events[`BPSW_EV_SHORT] = 1'b1;
    end else begin
      case (state_q)
        ST_TAP_OFF, ST_TAP_UV: begin
          if (!tap_open) begin
            state_d = steady;
          end else if (state_q == ST_TAP_UV && (!pack_low || (off_sample && !charger))) begin
            state_d = ST_TAP_OFF;
          end else if (state_q == ST_TAP_OFF && pack_low && charger) begin
            state_d = ST_TAP_UV;
          end
        end
        ST_SHORT: begin
          if (any_deep || pack_low) begin
            state_d = ST_SHUTDOWN;
            events[`BPSW_EV_DEEP] = 1'b1;
          end else if (load_zero) begin
            state_d = steady;
          end
        end
        ST_DEEP_CHG: begin
          if (off_sample && !charger) begin
            state_d = ST_SHUTDOWN;
            events[`BPSW_EV_CHG_LOST] = 1'b1;
          end else if (!any_deep) begin
            state_d = steady;
          end
        end
        ST_UV_CHG: begin
          if (off_sample && !charger) begin
            state_d = ST_SHUTDOWN;
            events[`BPSW_EV_CHG_LOST] = 1'b1;
          end else if (!pack_low) begin
            state_d = ST_DEEP_CHG;
          end
        end
        ST_OC_CHG: begin
          if (!any_over || !charger) begin
            state_d = steady;
            oc_cnt_d = {(`BPSW_DELAY_W+1){1'b0}};
          end else if (tick) begin
            // Two ticks of persistence, then the programmed extra charge time
            if (oc_cnt_q >= oc_limit) begin
              state_d = ST_OC_OFF;
              oc_cnt_d = {(`BPSW_DELAY_W+1){1'b0}};
              events[`BPSW_EV_OC_CUT] = 1'b1;
            end else begin
              oc_cnt_d = oc_cnt_q + 1'b1;
            end
          end
        end
        ST_OC_OFF: begin
          if (!any_over || !charger) begin
            state_d = steady;
          end
        end
        ST_IDLE, ST_NORMAL, ST_SHUTDOWN: begin
          state_d = steady;
          if (state_q != ST_SHUTDOWN && steady == ST_SHUTDOWN) begin
            events[`BPSW_EV_DEEP] = 1'b1;
          end
          if (steady != ST_OC_CHG) begin
            oc_cnt_d = {(`BPSW_DELAY_W+1){1'b0}};
          end
        end
        default: begin
          state_d = ST_SHUTDOWN;
        end
      endcase
    end
  end

  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q <= ST_SHUTDOWN;
      oc_cnt_q <= {(`BPSW_DELAY_W+1){1'b0}};
    end else begin
      state_q <= state_d;
      oc_cnt_q <= oc_cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // Gate and sink drive
  // ----------------------------------------------------------------
  // Registered so a decode hazard never reaches the MOSFET gate
  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_switch_gate_drive <= 1'b0;
      o_short_release_sink <= 1'b0;
    end else begin
      case (state_d)
        ST_NORMAL, ST_OC_CHG: o_switch_gate_drive <= ~force_off_q;
        ST_DEEP_CHG: o_switch_gate_drive <= gate_7of8 & ~force_off_q;
        ST_UV_CHG, ST_TAP_UV: o_switch_gate_drive <= gate_1of8 & ~force_off_q;
        default: o_switch_gate_drive <= 1'b0;
      endcase
      o_short_release_sink <= (state_d == ST_SHORT);
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  reg aw_held_q;
  reg w_held_q;
  reg [`BPSW_ADDR_W-1:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;

  // Address decode shared by both directions
  function mapped;
    input [`BPSW_ADDR_W-1:0] a;
    begin
      mapped = (a == `BPSW_OFF_CTRL) || (a == `BPSW_OFF_DELAY) ||
               (a == `BPSW_OFF_STATE) || (a == `BPSW_OFF_IRQ_STAT) ||
               (a == `BPSW_OFF_IRQ_MASK);
    end
  endfunction

  assign o_awready = ~aw_held_q & ~o_bvalid;
  assign o_wready = ~w_held_q & ~o_bvalid;
  assign o_arready = ~o_rvalid;
  wire do_write = aw_held_q & w_held_q & ~o_bvalid;
  wire do_read = i_arvalid & o_arready;
  wire stat_read = do_read && (i_araddr == `BPSW_OFF_IRQ_STAT);

  // Write channel capture, either order
  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= {`BPSW_ADDR_W{1'b0}};
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      o_bvalid <= 1'b0;
      o_bresp <= `BPSW_RESP_OKAY;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_held_q <= 1'b1;
        wdata_q <= i_wdata;
        wstrb_q <= i_wstrb;
      end
      if (do_write) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp <= mapped(awaddr_q) ? `BPSW_RESP_OKAY : `BPSW_RESP_SLVERR;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  // Writable registers; status and state are read-only
  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      force_off_q <= `BPSW_CTRL_RST;
      oc_delay_q <= `BPSW_DELAY_RST;
      irq_mask_q <= `BPSW_IRQ_MASK_RST;
    end else if (do_write && wstrb_q[0]) begin
      if (awaddr_q == `BPSW_OFF_CTRL) begin
        force_off_q <= wdata_q[`BPSW_CTRL_FORCE_OFF];
      end
      if (awaddr_q == `BPSW_OFF_DELAY) begin
        oc_delay_q <= wdata_q[`BPSW_DELAY_W-1:0];
      end
      if (awaddr_q == `BPSW_OFF_IRQ_MASK) begin
        irq_mask_q <= wdata_q[`BPSW_IRQ_W-1:0];
      end
    end
  end

  // Sticky events: a read clears, but a new event in that cycle survives
  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_stat_q <= {`BPSW_IRQ_W{1'b0}};
    end else begin
      irq_stat_q <= (stat_read ? {`BPSW_IRQ_W{1'b0}} : irq_stat_q) | events;
    end
  end

  assign o_irq = |(irq_stat_q & irq_mask_q);

  // Read data, one cycle after the address is taken
  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rvalid <= 1'b0;
      o_rdata <= 32'h00000000;
      o_rresp <= `BPSW_RESP_OKAY;
    end else if (do_read) begin
      o_rvalid <= 1'b1;
      o_rresp <= mapped(i_araddr) ? `BPSW_RESP_OKAY : `BPSW_RESP_SLVERR;
      case (i_araddr)
        `BPSW_OFF_CTRL: o_rdata <= {31'h00000000, force_off_q};
        `BPSW_OFF_DELAY: o_rdata <= {24'h000000, oc_delay_q};
        `BPSW_OFF_STATE: o_rdata <= {14'h0000, flags_q, phase_q,
                                     o_short_release_sink, o_switch_gate_drive, state_q};
        `BPSW_OFF_IRQ_STAT: o_rdata <= {27'h0000000, irq_stat_q};
        `BPSW_OFF_IRQ_MASK: o_rdata <= {27'h0000000, irq_mask_q};
        default: o_rdata <= 32'h00000000;
      endcase
    end else if (o_rvalid && i_rready) begin
      o_rvalid <= 1'b0;
    end
  end

endmodule // bpsw_fsm

// ---- rtl/bpsw_consts.vh ----
`ifndef BPSW_CONSTS_VH
`define BPSW_CONSTS_VH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define BPSW_CLK_HZ 10000000
`define BPSW_TICK_MS 4
`define BPSW_TICK_CYCLES ((`BPSW_CLK_HZ / 1000) * `BPSW_TICK_MS)
`define BPSW_OC_PERSIST_TICKS 2
`define BPSW_DUTY_PHASES 8
`define BPSW_LAST_PHASE 3'h7

// ----------------------------------------------------------------
// Register map, byte addresses
// ----------------------------------------------------------------
`define BPSW_ADDR_W 8
`define BPSW_OFF_CTRL 8'h00
`define BPSW_OFF_DELAY 8'h04
`define BPSW_OFF_STATE 8'h08
`define BPSW_OFF_IRQ_STAT 8'h0C
`define BPSW_OFF_IRQ_MASK 8'h10

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define BPSW_CTRL_FORCE_OFF 0
`define BPSW_CTRL_RST 1'h0
`define BPSW_DELAY_W 8
`define BPSW_DELAY_RST 8'h10
`define BPSW_IRQ_W 5
`define BPSW_IRQ_MASK_RST 5'h00
`define BPSW_EV_SHORT 0
`define BPSW_EV_TAP 1
`define BPSW_EV_DEEP 2
`define BPSW_EV_OC_CUT 3
`define BPSW_EV_CHG_LOST 4
`define BPSW_RESP_OKAY 2'h0
`define BPSW_RESP_SLVERR 2'h2

`endif

// ---- bench/bpsw_fsm_checker.sv ----
`timescale 1ns/1ps

module bpsw_fsm_checker #(
  parameter TICK_CYCLES = 8
) (
  input wire i_clk_sys,
  input wire i_resetn,
  input wire i_hi_cell_deep_discharged_cell,
  input wire i_lo_cell_deep_discharged_cell,
  input wire i_pack_low_voltage,
  input wire i_charger_present,
  input wire i_load_short,
  input wire i_load_zero,
  input wire i_tap_open,
  input wire o_switch_gate_drive,
  input wire o_short_release_sink,
  input wire i_awvalid,
  input wire o_awready,
  input wire i_wvalid,
  input wire o_wready,
  input wire o_bvalid,
  input wire i_arvalid,
  input wire o_arready,
  input wire o_rvalid
);
  wire deep = i_hi_cell_deep_discharged_cell | i_lo_cell_deep_discharged_cell;
  reg [15:0] dc_q;
  reg [15:0] on_q;
  reg [15:0] nd_q;
  reg [15:0] nl_q;

  // Run lengths of deep with and without charger, of pack low without charger and of gate-on; saturating so long runs never wrap
  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      dc_q <= 16'h0000;
      on_q <= 16'h0000;
      nd_q <= 16'h0000;
      nl_q <= 16'h0000;
    end else begin
      dc_q <= (deep && i_charger_present) ? dc_q + {15'h0000, ~&dc_q} : 16'h0000;
      on_q <= o_switch_gate_drive ? on_q + {15'h0000, ~&on_q} : 16'h0000;
      nd_q <= (deep && !i_charger_present) ? nd_q + {15'h0000, ~&nd_q} : 16'h0000;
      nl_q <= (i_pack_low_voltage && !i_charger_present) ? nl_q + {15'h0000, ~&nl_q} : 16'h0000;
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);

  sequence s_wr_taken;
    i_awvalid && o_awready && i_wvalid && o_wready;
  endsequence
  sequence s_rd_taken;
    i_arvalid && o_arready;
  endsequence

  // Flags cross two sync stages and the gate register, so allow six cycles
  a_tap_opens_switch: assert property (
    (i_tap_open && !i_pack_low_voltage)[*6] |-> !o_switch_gate_drive)
    else $error("gate on while tap open");
  a_short_opens_switch: assert property (
    i_load_short && o_switch_gate_drive |-> ##[1:4] !o_switch_gate_drive)
    else $error("gate stayed on under short");
  a_sink_only_off: assert property (
    o_short_release_sink |-> !o_switch_gate_drive)
    else $error("sink on with gate on");
  a_sink_holds_on: assert property (
    (o_short_release_sink && !i_load_zero && !deep && !i_pack_low_voltage)[*4]
    |=> o_short_release_sink)
    else $error("sink dropped with short present");
  // A cycling mode notices a lost charger only at its next off tick, up to a period later
  a_deep_shuts_off: assert property (
    nd_q > 8 * TICK_CYCLES + 6 |-> !o_switch_gate_drive)
    else $error("gate on with deep cell and no charger");
  a_lockout_opens: assert property (
    nl_q > 8 * TICK_CYCLES + 6 |-> !o_switch_gate_drive)
    else $error("gate on below lockout");
  // A cycling mode must open the gate at least once in every eight-tick period
  a_duty_has_gap: assert property (
    dc_q > 16 * TICK_CYCLES |-> on_q <= 8 * TICK_CYCLES)
    else $error("no off tick while cycling");
  a_write_answer: assert property (
    s_wr_taken |=> ##1 o_bvalid ##0 (!o_awready && !o_wready))
    else $error("write response missing");
  a_read_answer: assert property (
    s_rd_taken |=> o_rvalid ##0 !o_arready)
    else $error("read response missing");
endmodule // bpsw_fsm_checker

bind bpsw_fsm bpsw_fsm_checker #(.TICK_CYCLES(TICK_CYCLES)) bpsw_fsm_checker_inst (.*);

// ---- bench/bpsw_load_model.sv ----
`timescale 1ns/1ps

module bpsw_load_model (
  input wire i_gate,
  input wire i_short_on,
  input wire i_load_on,
  input wire i_charger_on,
  output wire o_load_short,
  output wire o_load_zero,
  output wire o_charger_present
);
  // Sense voltage builds only while the switch conducts; an open switch hides a short
  assign o_load_short = i_gate & i_short_on;
  // With no load of any kind the pack terminal falls back to the cell terminal
  assign o_load_zero = ~(i_short_on | i_load_on);
  // A charger above the detect threshold is the only source of this flag
  assign o_charger_present = i_charger_on;
endmodule // bpsw_load_model

// ---- bench/bpsw_fsm_tb_top.sv ----
`timescale 1ns/1ps
`include "bpsw_consts.vh"
`define CHK(nm, e, a) begin n_tests++; if ((a) !== (e)) begin n_errors++; \
  $display("BAD %s exp %0h got %0h", nm, e, a); end end

module bpsw_fsm_tb_top;
  localparam int TK = 8;
  localparam int PER = 8 * TK;
  reg clk = 1'b0;
  reg rstn = 1'b0;
  reg [7:0] fv = 8'h00; // {tap, pack low, hi deep, lo deep, hi over, charger, short, load}
  reg awv = 1'b0;
  reg wv = 1'b0;
  reg br = 1'b0;
  reg arv = 1'b0;
  reg rr = 1'b0;
  reg [7:0] awa = 8'h00;
  reg [7:0] ara = 8'h00;
  reg [31:0] wd = 32'h0;
  reg [31:0] rdv;
  wire gate, sink, irq, awr, wr_rdy, bv, arr, rv, shrt, zero, chgp;
  wire [1:0] bresp;
  wire [1:0] rresp;
  wire [31:0] rdata;
  integer n_errors = 0;
  integer n_tests = 0;

  // Short tick keeps a duty period at 64 cycles
  bpsw_fsm #(.TICK_CYCLES(TK)) bpsw_fsm_inst (
    .i_clk_sys(clk), .i_resetn(rstn),
    .i_hi_cell_deep_discharged_cell(fv[5]), .i_hi_cell_overcharged(fv[3]),
    .i_lo_cell_deep_discharged_cell(fv[4]), .i_lo_cell_overcharged(1'b0),
    .i_pack_low_voltage(fv[6]), .i_charger_present(chgp), .i_load_short(shrt),
    .i_load_zero(zero), .i_tap_open(fv[7]), .o_switch_gate_drive(gate),
    .o_short_release_sink(sink), .o_irq(irq), .i_awvalid(awv), .o_awready(awr),
    .i_awaddr(awa), .i_wvalid(wv), .o_wready(wr_rdy), .i_wdata(wd), .i_wstrb(4'hF),
    .o_bvalid(bv), .i_bready(br), .o_bresp(bresp), .i_arvalid(arv), .o_arready(arr),
    .i_araddr(ara), .o_rvalid(rv), .i_rready(rr), .o_rdata(rdata), .o_rresp(rresp));

  bpsw_load_model bpsw_load_model_inst (
    .i_gate(gate), .i_short_on(fv[1]), .i_load_on(fv[0]), .i_charger_on(fv[2]),
    .o_load_short(shrt), .o_load_zero(zero), .o_charger_present(chgp));

  // Free-running system clock
  initial begin
    forever #50 clk = ~clk;
  end

  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask

  // Waits end at a falling edge so outputs are settled when sampled
  task automatic at(input integer n);
    begin
      repeat (n) @(posedge clk);
      @(negedge clk);
    end
  endtask

  // Only the watchdog ends a wait for the slave
  task automatic rd(input [7:0] a, input [1:0] er);
    begin
      @(posedge clk);
      ara <= a;
      arv <= 1'b1;
      @(negedge clk);
      while (!arr) @(negedge clk);
      @(posedge clk);
      arv <= 1'b0;
      rr <= 1'b1;
      @(negedge clk);
      while (!rv) @(negedge clk);
      rdv = rdata;
      `CHK("rresp", er, rresp)
      @(posedge clk);
      rr <= 1'b0;
      @(negedge clk);
    end
  endtask

  // Address and data offered together; each dropped only after its own handshake
  task automatic wr(input [7:0] a, input [31:0] d, input [1:0] er);
    reg ta, tw;
    begin
      @(posedge clk);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      ta = 1'b0;
      tw = 1'b0;
      while (!(ta && tw)) begin
        @(negedge clk);
        ta = ta | (awv & awr);
        tw = tw | (wv & wr_rdy);
        @(posedge clk);
        if (ta) awv <= 1'b0;
        if (tw) wv <= 1'b0;
      end
      br <= 1'b1;
      @(negedge clk);
      while (!bv) @(negedge clk);
      `CHK("bresp", er, bresp)
      @(posedge clk);
      br <= 1'b0;
      @(negedge clk);
    end
  endtask

  // Counts gate-on cycles over one full duty period
  task automatic duty(input string nm, input integer e);
    integer k, c;
    begin
      c = 0;
      for (k = 0; k < PER; k++) begin
        @(negedge clk);
        c = c + gate;
      end
      `CHK(nm, e, c)
    end
  endtask

  task automatic t_regs;
    begin
      rd(`BPSW_OFF_CTRL, `BPSW_RESP_OKAY);
      `CHK("ctrl", 32'h0, rdv)
      rd(`BPSW_OFF_DELAY, `BPSW_RESP_OKAY);
      `CHK("delay", 32'h10, rdv)
      rd(`BPSW_OFF_IRQ_MASK, `BPSW_RESP_OKAY);
      `CHK("mask", 32'h0, rdv)
      rd(8'h40, `BPSW_RESP_SLVERR);
      `CHK("unmapped", 32'h0, rdv)
      wr(8'h40, 32'h1, `BPSW_RESP_SLVERR);
      // Cells in range keep the switch on; an aliased write would force it off
      `CHK("wr_ignored", 1'b1, gate)
      $display("done regs");
    end
  endtask

  task automatic t_deep;
    begin
      @(posedge clk) fv <= 8'h01;
      at(8);
      `CHK("gate_norm", 1'b1, gate)
      @(posedge clk) fv <= 8'h14;
      at(2 * PER);
      duty("duty78", 7 * TK);
      @(posedge clk) fv <= 8'h04;
      at(PER);
      duty("back_on", PER);
      $display("done deep");
    end
  endtask

  task automatic t_uv;
    begin
      @(posedge clk) fv <= 8'h50;
      at(8);
      `CHK("uv_off", 1'b0, gate)
      @(posedge clk) fv <= 8'h54;
      at(2 * PER);
      duty("duty18", TK);
      @(posedge clk) fv <= 8'h14;
      at(2 * PER);
      duty("uv_exit", 7 * TK);
      @(posedge clk) fv <= 8'h10;
      at(2 * PER);
      `CHK("chg_lost", 1'b0, gate)
      $display("done uv");
    end
  endtask

  task automatic t_short;
    begin
      @(posedge clk) fv <= 8'h01;
      wr(`BPSW_OFF_IRQ_MASK, 32'h1, `BPSW_RESP_OKAY);
      rd(`BPSW_OFF_IRQ_STAT, `BPSW_RESP_OKAY);
      at(8);
      `CHK("gate_load", 1'b1, gate)
      `CHK("irq_idle", 1'b0, irq)
      @(posedge clk) fv <= 8'h03;
      at(6);
      `CHK("gate_short", 1'b0, gate)
      `CHK("sink_on", 1'b1, sink)
      `CHK("irq_on", 1'b1, irq)
      at(PER);
      `CHK("gate_held", 1'b0, gate)
      rd(`BPSW_OFF_IRQ_STAT, `BPSW_RESP_OKAY);
      `CHK("stat", 32'h1, rdv)
      `CHK("irq_clr", 1'b0, irq)
      @(posedge clk) fv <= 8'h00;
      at(8);
      `CHK("sink_gone", 1'b0, sink)
      @(posedge clk) fv <= 8'h01;
      at(8);
      @(posedge clk) fv <= 8'h03;
      at(8);
      `CHK("sink_again", 1'b1, sink)
      @(posedge clk) fv <= 8'h13;
      at(8);
      `CHK("sink_deep", 1'b0, sink)
      $display("done short");
    end
  endtask

  task automatic t_tap;
    begin
      @(posedge clk) fv <= 8'h01;
      at(8);
      @(posedge clk) fv <= 8'h81;
      at(PER);
      `CHK("tap_off", 1'b0, gate)
      @(posedge clk) fv <= 8'h01;
      at(8);
      `CHK("tap_back", 1'b1, gate)
      @(posedge clk) fv <= 8'hC4;
      at(2 * PER);
      duty("tap18", TK);
      @(posedge clk) fv <= 8'h84;
      at(2 * PER);
      `CHK("tap_end", 1'b0, gate)
      $display("done tap");
    end
  endtask

  task automatic t_oc;
    begin
      wr(`BPSW_OFF_DELAY, 32'h1, `BPSW_RESP_OKAY);
      @(posedge clk) fv <= 8'h0C;
      at(3 * TK);
      `CHK("oc_early", 1'b1, gate)
      at(TK + 8);
      `CHK("oc_cut", 1'b0, gate)
      @(posedge clk) fv <= 8'h09;
      at(8);
      `CHK("oc_load", 1'b1, gate)
      @(posedge clk) fv <= 8'h08;
      at(8);
      `CHK("oc_idle", 1'b0, gate)
      @(posedge clk) fv <= 8'h09;
      at(8);
      `CHK("oc_reload", 1'b1, gate)
      wr(`BPSW_OFF_CTRL, 32'h1, `BPSW_RESP_OKAY);
      at(4);
      `CHK("forced", 1'b0, gate)
      wr(`BPSW_OFF_CTRL, 32'h0, `BPSW_RESP_OKAY);
      at(8);
      `CHK("unforced", 1'b1, gate)
      @(posedge clk) fv <= 8'h29;
      at(8);
      `CHK("both_class", 1'b0, gate)
      $display("done oc");
    end
  endtask

  // Main sequence after ten cycles of reset
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    t_regs;
    t_deep;
    t_uv;
    t_short;
    t_tap;
    t_oc;
    give_verdict;
  end

  // Watchdog well beyond the roughly fifteen hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    give_verdict;
  end
endmodule // bpsw_fsm_tb_top
